/* rtl/tsi_pkg.sv */
// Shared constants and types for the time slot switch path control.
package tsi_pkg;
  // Memory geometry: 16 streams of 256 channels, one slot per clock.
  localparam int          SLOTS      = 4096;
  localparam logic [11:0] LAST_SLOT  = 12'hFFF;
  localparam logic [11:0] SLOT_STEP  = 12'h001;
  localparam logic [1:0]  BANK_LAST  = 2'h2;
  localparam logic [1:0]  BANK_STEP  = 2'h1;
  localparam logic [1:0]  BANK_FIRST = 2'h0;

  // Register values seen by the host.
  localparam logic [15:0] CTRL_RESET = 16'h4000;
  localparam logic [15:0] OFS_RESET  = 16'h0000;
  localparam logic [15:0] FAR_VALUE  = 16'h0000;
  localparam logic [15:0] UNMAPPED   = 16'h0000;

  // Control register bit positions.
  localparam int CR_SRST    = 15;
  localparam int CR_POL     = 13;
  localparam int CR_ARM     = 11;
  localparam int CR_PAT_HI  = 9;
  localparam int CR_PAT_LO  = 7;
  localparam int CR_START   = 6;
  localparam int CR_STBY    = 5;
  localparam int CR_RATE_HI = 3;
  localparam int CR_RATE_LO = 0;

  // Connection memory word layout.
  localparam int          CM_MODE_HI = 15;
  localparam int          CM_MODE_LO = 14;
  localparam int          CM_CHANNEL_LOOPBACK_BIT    = 13;
  localparam logic [12:0] CM_LOW_CLR = 13'h0000;

  // Per-channel mode field codes.
  localparam logic [1:0] MODE_VAR   = 2'h0;
  localparam logic [1:0] MODE_CONST = 2'h1;
  localparam logic [1:0] MODE_PROC  = 2'h2;
  localparam logic [1:0] MODE_HIZ   = 2'h3;

  // Variable delay slot gaps.
  localparam logic [3:0]  RATE_16_16 = 4'h3;
  localparam logic [11:0] GAP_NORMAL = 12'h003;
  localparam logic [11:0] GAP_FAST   = 12'h006;

  // Host address decode.
  localparam logic [1:0] SEL_DM   = 2'h3;
  localparam logic [1:0] SEL_CM   = 2'h2;
  localparam logic [1:0] SEL_REG  = 2'h1;
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_FAR  = 3'h1;
  localparam logic [2:0] REG_OFS0 = 3'h2;
  localparam logic [2:0] REG_OFS3 = 3'h5;

  // Output word: stream, channel, byte, drive, indication.
  localparam int TX_W = 22;

  typedef enum logic [2:0] {REGION_DM, REGION_CM, REGION_CTRL, REGION_FAR, REGION_OFS,
                            REGION_NONE} region_t;
  typedef enum logic {BP_IDLE, BP_FILL} bp_state_t;

  typedef struct packed {
    logic [15:0]      ctrl;
    logic [3:0][15:0] ofs;
    logic [11:0]      slot;
    logic [1:0]       bank;
    bp_state_t        bp;
    logic [11:0]      bp_addr;
    logic [2:0]       ode_sync;
    logic             ode_q;
    logic [15:0]      rdata;
  } switch_state_t;
endpackage

/* rtl/slot_buffer.sv */
// Two-entry valid/ready buffer on the outgoing slot path.
`timescale 1ns/10ps
module slot_buffer #(
  parameter int W = 22
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic              rd_ptr;
    logic              wr_ptr;
    logic [1:0]        count;
  } buf_state_t;

  buf_state_t q_r;
  buf_state_t q_nxt;
  logic       push;
  logic       pop;

  // Full at two words, empty at none; the stored word drives the output directly.
  assign in_ready  = (q_r.count != 2'h2);
  assign out_valid = (q_r.count != 2'h0);
  assign out_data  = q_r.mem[q_r.rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Pointer and occupancy update.
  always_comb begin
    q_nxt = q_r;
    if (push) begin
      q_nxt.mem[q_r.wr_ptr] = in_data;
      q_nxt.wr_ptr          = ~q_r.wr_ptr;
    end
    if (pop) begin
      q_nxt.rd_ptr = ~q_r.rd_ptr;
    end
    if (push && !pop) begin
      q_nxt.count = q_r.count + 2'h1;
    end else if (pop && !push) begin
      q_nxt.count = q_r.count - 2'h1;
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (srst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end
endmodule // slot_buffer

/* rtl/tsi_switch_path_control.sv */
// Per-channel path control, memories and host port of the time slot switch.
// Functional notes
// - Mode field zero selects variable delay, set by stream rate pairing.
// - Variable delay: source three slots ahead leaves in the same frame.
// - Both streams at 16 Mb/s: same-frame delay needs at least six slots.
// - Mode 0x1 selects constant delay: frame n data leaves in frame n+2.
// - Constant delay lies between one frame plus one slot and three frames less one slot.
// - Host port: 14-bit address, 16-bit data, one clock per access.
// - Top address bits 11 read data memory; byte on low eight data lines.
// - Top bits 10 read and write connection memory by stream and channel.
// - Top bits 01: bits 11..9 select control, alignment or four offset registers.
// - With drive pin or standby high, mode 11 three-states, others drive.
// - Mode 10 sends the low connection memory byte every frame.
// - Loopback bit feeds output stream n channel m into input n channel m.
// - Start bit fills connection memory with pattern only while armed.
// - Reset loads defaults, three-states outputs, leaves connection memory undefined.
// - Each output slot carries an indication of driven or three-stated.
// - Drive pin and standby both low three-state every output.
// - Fill writes pattern to bits 15..13, zero below, then clears start.
// - Polarity one: indication high means driven; zero inverts the sense.
`timescale 1ns/10ps
module tsi_switch_path_control
  import tsi_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        drive_enable_pin,
  input  wire logic        host_cs,
  input  wire logic        host_rd,
  input  wire logic        host_wr,
  input  wire logic [13:0] host_addr,
  input  wire logic [15:0] host_wdata,
  output logic      [15:0] host_rdata,
  input  wire logic [7:0]  rx_byte,
  output logic             rx_ready,
  output logic      [3:0]  rx_stream,
  output logic      [7:0]  rx_channel,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic      [3:0]  tx_stream,
  output logic      [7:0]  tx_channel,
  output logic      [7:0]  tx_byte,
  output logic             tx_drive,
  output logic             tx_indication
);
  switch_state_t q_r;
  switch_state_t q_nxt;
  logic [15:0]   cm_mem [SLOTS];
  logic [7:0]    dm_mem [3][SLOTS];
  region_t       region;
  logic [15:0]   cm_word;
  logic [11:0]   src;
  logic [1:0]    mode;
  logic [11:0]   gap;
  logic          same_frame;
  logic [1:0]    rd_bank;
  logic [7:0]    out_byte;
  logic          drive;
  logic          ind;
  logic          run;
  logic          buf_ready;
  logic          advance;
  logic          host_wr_cm;
  logic          buf_srst;
  logic [1:0]    ofs_idx;
  logic [TX_W-1:0] tx_word;

  // Defaults loaded by the reset pin and by the software reset bit.
  function automatic switch_state_t reset_state();
    switch_state_t s;
    s      = '0;
    s.ctrl = CTRL_RESET;
    s.ofs  = {4{OFS_RESET}};
    return s;
  endfunction

  // Address decode shared by reads and writes.
  function automatic region_t region_of(input logic [13:0] a);
    region_t r;
    r = REGION_NONE;
    if (a[13:12] == SEL_DM) begin
      r = REGION_DM;
    end else if (a[13:12] == SEL_CM) begin
      r = REGION_CM;
    end else if (a[13:12] == SEL_REG) begin
      if (a[11:9] == REG_CTRL) begin
        r = REGION_CTRL;
      end else if (a[11:9] == REG_FAR) begin
        r = REGION_FAR;
      end else if (a[11:9] >= REG_OFS0 && a[11:9] <= REG_OFS3) begin
        r = REGION_OFS;
      end
    end
    return r;
  endfunction

  function automatic logic [1:0] bank_prev(input logic [1:0] b);
    return (b == BANK_FIRST) ? BANK_LAST : b - BANK_STEP;
  endfunction

  function automatic logic [1:0] bank_next(input logic [1:0] b);
    return (b == BANK_LAST) ? BANK_FIRST : b + BANK_STEP;
  endfunction

  // Host decode.
  assign region     = region_of(host_addr);
  assign ofs_idx    = 2'(host_addr[11:9] - REG_OFS0);
  assign host_wr_cm = host_cs & host_wr & (region == REGION_CM) & (q_r.bp == BP_IDLE);

  // Slot path: the connection word of the current output slot picks the source.
  assign cm_word    = cm_mem[q_r.slot];
  assign src        = cm_word[11:0];
  assign mode       = cm_word[CM_MODE_HI:CM_MODE_LO];
  assign gap        = (q_r.ctrl[CR_RATE_HI:CR_RATE_LO] == RATE_16_16) ? GAP_FAST
                                                                       : GAP_NORMAL;
  assign same_frame = (src < q_r.slot) && ((q_r.slot - src) >= gap);

  // Bank choice: constant reads the bank written two frames back, variable the newest safe one.
  always_comb begin
    if (mode == MODE_CONST) begin
      rd_bank = bank_next(q_r.bank);
    end else if (same_frame) begin
      rd_bank = q_r.bank;
    end else begin
      rd_bank = bank_prev(q_r.bank);
    end
  end

  assign out_byte = (mode == MODE_PROC) ? cm_word[7:0] : dm_mem[rd_bank][src];
  assign drive    = (q_r.ode_q | q_r.ctrl[CR_STBY]) & (mode != MODE_HIZ);
  assign ind      = q_r.ctrl[CR_POL] ? drive : ~drive;

  // The slot walk stalls whenever the output buffer is full.
  assign run       = ~srst & ~q_r.ctrl[CR_SRST];
  assign advance   = run & buf_ready;
  assign rx_ready  = advance;
  assign rx_stream  = q_r.slot[11:8];
  assign rx_channel = q_r.slot[7:0];
  assign host_rdata = q_r.rdata;
  assign buf_srst   = srst | q_r.ctrl[CR_SRST];
  assign tx_word    = {q_r.slot, out_byte, drive, ind};

  // Next-state logic for registers, slot counter, pin sync and block fill.
  always_comb begin
    q_nxt = q_r;
    q_nxt.ode_sync = {q_r.ode_sync[1:0], drive_enable_pin};
    if (q_r.ode_sync[1] == q_r.ode_sync[2]) begin
      q_nxt.ode_q = q_r.ode_sync[2];
    end
    if (advance) begin
      q_nxt.slot = q_r.slot + SLOT_STEP;
      if (q_r.slot == LAST_SLOT) begin
        q_nxt.bank = bank_next(q_r.bank);
      end
    end
    case (q_r.bp)
      BP_IDLE: begin
        if (q_r.ctrl[CR_START] && q_r.ctrl[CR_ARM]) begin
          q_nxt.bp      = BP_FILL;
          q_nxt.bp_addr = '0;
        end
      end
      BP_FILL: begin
        q_nxt.bp_addr = q_r.bp_addr + SLOT_STEP;
        if (q_r.bp_addr == LAST_SLOT) begin
          q_nxt.bp              = BP_IDLE;
          q_nxt.ctrl[CR_START]  = 1'b0;
        end
      end
      default: begin
        q_nxt.bp = BP_IDLE;
      end
    endcase
    if (host_cs && host_rd) begin
      case (region)
        REGION_DM:   q_nxt.rdata = {8'h00, dm_mem[bank_prev(q_r.bank)][host_addr[11:0]]};
        REGION_CM:   q_nxt.rdata = cm_mem[host_addr[11:0]];
        REGION_CTRL: q_nxt.rdata = q_r.ctrl;
        REGION_FAR:  q_nxt.rdata = FAR_VALUE;
        REGION_OFS:  q_nxt.rdata = q_r.ofs[ofs_idx];
        default:     q_nxt.rdata = UNMAPPED;
      endcase
    end
    // Host writes follow the fill logic so a written start bit wins over the hardware clear.
    if (host_cs && host_wr) begin
      case (region)
        REGION_CTRL: q_nxt.ctrl = host_wdata;
        REGION_OFS:  q_nxt.ofs[ofs_idx] = host_wdata;
        default:     q_nxt.rdata = q_nxt.rdata;
      endcase
    end
    if (q_r.ctrl[CR_SRST]) begin
      q_nxt = reset_state();
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (srst) begin
      q_r <= reset_state();
    end else begin
      q_r <= q_nxt;
    end
  end

  // Memories carry no reset; connection memory is undefined until programmed.
  always_ff @(posedge clk) begin
    if (advance) begin
      dm_mem[q_r.bank][q_r.slot] <= cm_word[CM_CHANNEL_LOOPBACK_BIT] ? out_byte : rx_byte;
    end
    if (q_r.bp == BP_FILL) begin
      cm_mem[q_r.bp_addr] <= {q_r.ctrl[CR_PAT_HI:CR_PAT_LO], CM_LOW_CLR};
    end else if (host_wr_cm) begin
      cm_mem[host_addr[11:0]] <= host_wdata;
    end
  end

  slot_buffer #(
    .W (TX_W)
  ) u_out_buf (
    .clk       (clk),
    .srst      (buf_srst),
    .in_valid  (run),
    .in_ready  (buf_ready),
    .in_data   (tx_word),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  ({tx_stream, tx_channel, tx_byte, tx_drive, tx_indication})
  );

  // Checks on the slot path and host port.
  property p_var_same;
    @(posedge clk) disable iff (srst)
      (mode == MODE_VAR && same_frame) |-> (out_byte == dm_mem[q_r.bank][src]);
  endproperty
  a_var_same: assert property (p_var_same) else $error("variable same-frame read wrong bank");

  property p_fast_gap;
    @(posedge clk) disable iff (srst)
      (mode == MODE_VAR && q_r.ctrl[CR_RATE_HI:CR_RATE_LO] == RATE_16_16
       && (q_r.slot - src) < GAP_FAST) |-> (rd_bank != q_r.bank);
  endproperty
  a_fast_gap: assert property (p_fast_gap) else $error("fast pair left below six slots");

  property p_const_bank;
    @(posedge clk) disable iff (srst)
      (mode == MODE_CONST) |-> (rd_bank != q_r.bank && rd_bank != bank_prev(q_r.bank));
  endproperty
  a_const_bank: assert property (p_const_bank) else $error("constant delay not two frames");

  property p_proc_byte;
    @(posedge clk) disable iff (srst)
      (advance && mode == MODE_PROC && (!tx_valid || tx_ready))
      |=> (tx_valid && tx_byte == $past(cm_word[7:0])
           && {tx_stream, tx_channel} == $past(q_r.slot));
  endproperty
  a_proc_byte: assert property (p_proc_byte) else $error("processor byte not sent");

  property p_hiz_mode;
    @(posedge clk) disable iff (srst)
      (mode == MODE_HIZ) |-> !drive;
  endproperty
  a_hiz_mode: assert property (p_hiz_mode) else $error("mode 11 channel driven");

  property p_all_off;
    @(posedge clk) disable iff (srst)
      (!q_r.ode_q && !q_r.ctrl[CR_STBY]) |-> (!drive && ind == !q_r.ctrl[CR_POL]);
  endproperty
  a_all_off: assert property (p_all_off) else $error("output driven with pin and standby low");

  property p_polarity;
    @(posedge clk) disable iff (srst)
      drive |-> (ind == q_r.ctrl[CR_POL]);
  endproperty
  a_polarity: assert property (p_polarity) else $error("indication sense wrong");

  property p_fill_end;
    @(posedge clk) disable iff (srst)
      (q_r.bp == BP_FILL && q_r.bp_addr == LAST_SLOT && !(host_cs && host_wr))
      |=> (q_r.bp == BP_IDLE && !q_r.ctrl[CR_START]);
  endproperty
  a_fill_end: assert property (p_fill_end) else $error("start bit not cleared after fill");

  property p_unarmed;
    @(posedge clk) disable iff (srst)
      (q_r.bp == BP_IDLE && !q_r.ctrl[CR_ARM]) |=> (q_r.bp == BP_IDLE);
  endproperty
  a_unarmed: assert property (p_unarmed) else $error("fill began without arm");

  property p_ro_write;
    @(posedge clk) disable iff (srst)
      (host_cs && host_wr && (region == REGION_FAR || region == REGION_DM)
       && q_r.bp == BP_IDLE && !q_r.ctrl[CR_SRST]) |=> ($stable(q_r.ctrl) && $stable(q_r.ofs));
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only write changed a register");

  property p_ctrl_read;
    @(posedge clk) disable iff (srst)
      (host_cs && host_rd && region == REGION_CTRL && !q_r.ctrl[CR_SRST])
      |=> (host_rdata == $past(q_r.ctrl));
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control read not returned in one clock");

  property p_reset_off;
    @(posedge clk)
      srst |=> (!tx_valid && q_r.ctrl == CTRL_RESET);
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("reset left outputs or control set");
endmodule // tsi_switch_path_control

/* verification/host_model.sv */
// Behavioural host processor driving the RAM-like register port.
`timescale 1ns/10ps
module host_model (
  input  wire logic        clk,
  output logic             cs,
  output logic             rd,
  output logic             wr,
  output logic [13:0]      addr,
  output logic [15:0]      wdata,
  input  wire logic [15:0] rdata
);
  // The bus idles deselected from time zero.
  initial begin
    cs = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 14'h0000;
    wdata = 16'h0000;
  end

  // One access: request held for one edge, answer taken just after it.
  task automatic acc(input logic w, input logic [13:0] a, input logic [15:0] d,
                     output logic [15:0] q);
    @(posedge clk);
    #1;
    cs = 1'b1;
    wr = w;
    rd = !w;
    addr = a;
    wdata = d;
    @(posedge clk);
    #1;
    q = rdata;
    cs = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask
endmodule // host_model

/* verification/tb.sv */
// Self-checking bench for the time slot switch path control.
`timescale 1ns/10ps
module tb;
  import tsi_pkg::*;
  logic        clk, srst, pin, cs, rd, wr, tx_ready, rx_ready, tx_valid, tx_drive, tx_ind;
  logic [13:0] addr;
  logic [15:0] wdata, rdata, q;
  logic [7:0]  rx_byte, rx_channel, tx_channel, tx_byte;
  logic [3:0]  rx_stream, tx_stream;
  logic [11:0] nxt;
  logic [7:0]  ob [SLOTS];
  logic        dv [SLOTS];
  logic        iv [SLOTS];
  int          ofr [SLOTS];
  int          frm, tfrm, err_count, check_count;

  // Free-running clock at 25 ns.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  tsi_switch_path_control uut (
    .clk(clk), .srst(srst), .drive_enable_pin(pin), .host_cs(cs), .host_rd(rd),
    .host_wr(wr), .host_addr(addr), .host_wdata(wdata), .host_rdata(rdata),
    .rx_byte(rx_byte), .rx_ready(rx_ready), .rx_stream(rx_stream),
    .rx_channel(rx_channel), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_stream(tx_stream), .tx_channel(tx_channel), .tx_byte(tx_byte),
    .tx_drive(tx_drive), .tx_indication(tx_ind)
  );

  host_model host (
    .clk(clk), .cs(cs), .rd(rd), .wr(wr), .addr(addr), .wdata(wdata), .rdata(rdata)
  );

  // Each slot gets a byte made of the frame number and the channel nibble.
  always @(posedge clk) begin
    if (srst) frm <= 0;
    else if (rx_ready && {rx_stream, rx_channel} == LAST_SLOT) frm <= frm + 1;
    #1 rx_byte = {frm[3:0], rx_channel[3:0]};
  end

  // Records every accepted word; a lost or repeated word breaks the slot order.
  always @(posedge clk) begin
    if (srst) begin
      nxt <= 12'h000;
      tfrm <= 0;
    end else if (tx_valid && tx_ready) begin
      chk({4'h0, tx_stream, tx_channel}, {4'h0, nxt});
      ob[nxt] <= tx_byte;
      dv[nxt] <= tx_drive;
      iv[nxt] <= tx_ind;
      ofr[nxt] <= tfrm;
      nxt <= nxt + SLOT_STEP;
      if (nxt == LAST_SLOT) tfrm <= tfrm + 1;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [13:0] a, input logic [15:0] d);
    host.acc(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [13:0] a, input logic [15:0] e);
    host.acc(1'b0, a, 16'h0000, q);
    chk(q, e);
  endtask

  // Slot byte expected from a source nibble lagging the given number of frames.
  task automatic chk_slot(input logic [11:0] k, input int lag, input logic [3:0] nib);
    logic [3:0] f;
    f = 4'(ofr[k] - lag);
    chk({8'h00, ob[k]}, {8'h00, f, nib});
  endtask

  task automatic wait_frames(input int n);
    int t0;
    t0 = tfrm;
    repeat (5000 * n) if (tfrm < t0 + n) @(posedge clk);
    if (tfrm < t0 + n) chk(16'(tfrm), 16'(t0 + n));
    #1;
  endtask

  task automatic t_regs;
    rd_chk(14'h1000, CTRL_RESET);
    wr_reg(14'h1000, CTRL_RESET);
    for (int i = 0; i < 4; i++) rd_chk(14'h1400 + 14'(i * 512), OFS_RESET);
    wr_reg(14'h1600, 16'hBEEF);
    rd_chk(14'h1600, 16'hBEEF);
    wr_reg(14'h1600, OFS_RESET);
    wr_reg(14'h1200, 16'h1234);
    rd_chk(14'h1200, FAR_VALUE);
    wr_reg(14'h1C00, 16'hFFFF);
    rd_chk(14'h1C00, UNMAPPED);
  endtask

  task automatic t_fill;
    wr_reg(14'h1000, 16'h4B40);
    repeat (4100) @(posedge clk);
    chk({15'h0, dv[12'h000]}, 16'h0000);
    rd_chk(14'h1000, 16'h4B00);
    rd_chk(14'h2000, 16'hC000);
    rd_chk(14'h2FFF, 16'hC000);
    wr_reg(14'h1000, 16'h4040);
    repeat (4200) @(posedge clk);
    rd_chk(14'h1000, 16'h4040);
    rd_chk(14'h2ABC, 16'hC000);
    wr_reg(14'h1000, CTRL_RESET);
  endtask

  // Paths are set up while the drive pin stays low.
  task automatic t_program;
    wr_reg(14'h2105, 16'hA05A);
    wr_reg(14'h2210, 16'h020D);
    wr_reg(14'h2220, 16'h021E);
    wr_reg(14'h2230, 16'h022A);
    wr_reg(14'h2240, 16'h023B);
    wr_reg(14'h2250, 16'h424C);
    rd_chk(14'h2105, 16'hA05A);
    wait_frames(2);
    chk({14'h0, dv[12'h105], iv[12'h105]}, 16'h0001);
  endtask

  task automatic t_standby;
    logic [3:0] f;
    wr_reg(14'h1000, 16'h4020);
    wait_frames(2);
    chk({8'h00, ob[12'h105]}, 16'h005A);
    chk({14'h0, dv[12'h105], iv[12'h105]}, 16'h0002);
    chk({15'h0, dv[12'h106]}, 16'h0000);
    chk_slot(12'h210, 0, 4'hD);
    chk_slot(12'h220, 1, 4'hE);
    chk_slot(12'h230, 0, 4'hA);
    chk_slot(12'h240, 0, 4'hB);
    chk_slot(12'h250, 2, 4'hC);
    wr_reg(14'h3105, 16'h00FF);
    rd_chk(14'h3105, 16'h005A);
    f = 4'(frm - 1);
    rd_chk(14'h320D, {8'h00, f, 4'hD});
  endtask

  task automatic t_rate3;
    wr_reg(14'h2105, 16'h805A);
    wr_reg(14'h1000, 16'h4023);
    wait_frames(2);
    chk_slot(12'h230, 0, 4'hA);
    chk_slot(12'h240, 1, 4'hB);
    chk_slot(12'h210, 1, 4'hD);
  endtask

  // Pin raised only after the paths are programmed.
  task automatic t_pin;
    pin = 1'b1;
    wr_reg(14'h1000, 16'h6003);
    wait_frames(2);
    chk({14'h0, dv[12'h105], iv[12'h105]}, 16'h0003);
    chk({14'h0, dv[12'h106], iv[12'h106]}, 16'h0000);
  endtask

  // Receiver stalls; the walk must stop and no word may be lost.
  task automatic t_stall;
    tx_ready = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk({14'h0, tx_valid, rx_ready}, 16'h0002);
    tx_ready = 1'b1;
    wait_frames(1);
  endtask

  // Software reset with the receiver stalled: control self-clears, the walk restarts at slot 0.
  task automatic t_swrst;
    tx_ready = 1'b0;
    wr_reg(14'h1000, 16'hC023);
    rd_chk(14'h1000, CTRL_RESET);
    chk({3'h0, tx_valid, tx_stream, tx_channel}, 16'h1000);
  endtask

  task automatic wrap_up;
    $display("errors=%0d checks=%0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Main sequence after a 12-cycle reset.
  initial begin
    srst = 1'b1;
    pin = 1'b0;
    tx_ready = 1'b1;
    err_count = 0;
    check_count = 0;
    repeat (12) @(posedge clk);
    #1 srst = 1'b0;
    t_regs();
    t_fill();
    t_program();
    t_standby();
    t_rate3();
    t_pin();
    t_stall();
    t_swrst();
    wrap_up();
  end

  // Watchdog against a hung run.
  initial begin
    repeat (80000) @(posedge clk);
    err_count++;
    wrap_up();
  end
endmodule // tb
